// [rtl/dcff_params.svh]
/*
 Constants of the clocked FIFO flag-timing block: array size, offsets,
 serial programming length and output buffer depth.
 Assumes inclusion by the package and the design modules.
*/
`ifndef DCFF_PARAMS_SVH
`define DCFF_PARAMS_SVH

`define DCFF_DATA_W 36
`define DCFF_DEPTH 1024
`define DCFF_ADDR_W 10
`define DCFF_PTR_W 11
`define DCFF_OFFSET_W 10
`define DCFF_OFFSET_RESET 10'h008
`define DCFF_SERIAL_BITS 20
`define DCFF_SERIAL_CNT_W 5
`define DCFF_OUT_FIFO_DEPTH 4

`endif

// [rtl/dcff_pkg.sv]
/*
 Types of the clocked FIFO flag-timing block: programming phases and the
 port signal groups.
 Assumes dcff_params.svh is on the include path.
*/
`include "dcff_params.svh"

package dcff_pkg;

   typedef enum logic [1:0] {
      DCFF_PROG_X = 2'b00,
      DCFF_PROG_Y = 2'b01,
      DCFF_RUN = 2'b11
   } dcff_phase_type;

   typedef struct packed {
      logic port_a_chip_select_n;
      logic port_a_write_not_read;
      logic port_a_mail_select;
      logic port_a_enable;
      logic [`DCFF_DATA_W-1:0] port_a_data;
   } dcff_port_a_type;

   typedef struct packed {
      logic port_b_chip_select_n;
      logic port_b_write_not_read;
      logic port_b_mail_select;
      logic port_b_enable;
      logic retransmit_mode_request;
      logic replay_from_marker;
   } dcff_port_b_type;

   typedef struct packed {
      logic serial_program;
      logic serial_shift;
      logic serial_bit;
   } dcff_serial_type;

endpackage : dcff_pkg

// [rtl/dcff_out_fifo.sv]
/*
 Small FIFO with valid and ready on both sides.
 Assumes one clock; the drain side may stall at will.
*/
`timescale 1ns/10ps
`include "dcff_params.svh"

module dcff_out_fifo
   import dcff_pkg::*;
#(
   parameter int WIDTH = `DCFF_DATA_W,
   parameter int DEPTH = `DCFF_OUT_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] head;
      logic [AW-1:0] tail;
      logic [AW:0] count;
      logic valid;
      logic [WIDTH-1:0] data;
   } dcff_fifo_state_type;

   dcff_fifo_state_type state;
   dcff_fifo_state_type next_state;
   logic [WIDTH-1:0] store [DEPTH];
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////////
   assign in_ready = (state.count != (AW+1)'(DEPTH));
   // Head word and valid are registered so the drain side sees flop outputs
   assign out_valid = state.valid;
   assign out_data = state.data;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_state = state;
      if (push) begin
         next_state.head = (state.head == AW'(DEPTH - 1)) ? '0 : state.head + 1'b1;
      end
      if (pop) begin
         next_state.tail = (state.tail == AW'(DEPTH - 1)) ? '0 : state.tail + 1'b1;
      end
      if (push && !pop) begin
         next_state.count = state.count + 1'b1;
      end else if (pop && !push) begin
         next_state.count = state.count - 1'b1;
      end
      next_state.valid = (next_state.count != '0);
      // A word pushed into an emptying buffer bypasses the array
      if (push && (next_state.tail == state.head)) begin
         next_state.data = in_data;
      end else begin
         next_state.data = store[next_state.tail];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Storage needs no reset; the count guards it
   always_ff @(posedge clk) begin
      if (push) begin
         store[state.head] <= in_data;
      end
   end

endmodule : dcff_out_fifo

// [rtl/dcff_flag_timing.sv]
/*
 Clocked 1024 x 36 FIFO core: offset programming, fall-through output
 register, input-ready, output-ready, almost-full and almost-empty flags
 with synchronised pointer views, and read retransmit.
 Assumes one clock for both ports and synchronous inputs.
*/
// Notes on behaviour
// - Writes ignored until input ready rises
// - First word falls through within three cycles
// - Short skew may add one read cycle
// - Read from full raises input ready after sync
// - Almost-empty rises after write crosses X
// - Almost-full rises after read leaves range
// - Retransmit needs its two control inputs and output ready only
// - Retransmit lifts almost-empty after bounded latency
// - Leaving retransmit raises input ready after sync
// - Leaving retransmit raises almost-full after sync
// - Almost-empty low at X or fewer words
// - Almost-full low at 1024 minus Y words
// - Enter retransmit with request and output ready
// - Replay reloads read pointer from shadow pointer
`timescale 1ns/10ps
`include "dcff_params.svh"

module dcff_flag_timing
   import dcff_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire dcff_port_a_type port_a,
   input wire dcff_port_b_type port_b,
   input wire dcff_serial_type serial_in,
   output logic input_ready,
   output logic almost_full_flag_n,
   output logic output_ready,
   output logic almost_empty_flag_n,
   output logic retransmit_active,
   output logic b_data_valid,
   input wire logic b_data_ready,
   output logic [`DCFF_DATA_W-1:0] b_data
);

   typedef struct packed {
      dcff_phase_type phase;
      logic [`DCFF_OFFSET_W-1:0] x_offset;
      logic [`DCFF_OFFSET_W-1:0] y_offset;
      logic [`DCFF_SERIAL_CNT_W-1:0] serial_count;
      logic [`DCFF_PTR_W-1:0] wr_ptr;
      logic [`DCFF_PTR_W-1:0] rd_ptr;
      logic [`DCFF_PTR_W-1:0] shadow_ptr;
      logic [`DCFF_PTR_W-1:0] rd_view;
      logic [`DCFF_PTR_W-1:0] wr_sync1;
      logic [`DCFF_PTR_W-1:0] wr_sync2;
      logic [`DCFF_PTR_W-1:0] rd_sync1;
      logic [`DCFF_PTR_W-1:0] rd_sync2;
      logic retransmit_active;
      logic [`DCFF_DATA_W-1:0] out_word;
      logic output_ready;
      logic almost_empty_flag_n;
      logic almost_full_flag_n;
      logic input_ready;
   } dcff_state_type;

   dcff_state_type state;
   dcff_state_type next_state;
   logic [`DCFF_DATA_W-1:0] memory [`DCFF_DEPTH];
   logic a_write_select;
   logic b_read_select;
   logic fifo_write;
   logic fifo_read;
   logic buffer_ready;
   logic [`DCFF_PTR_W-1:0] words_a;
   logic [`DCFF_PTR_W-1:0] words_b;

   ////////////////////////////////////////////////////////////////////////
   // Port decode
   assign a_write_select = !port_a.port_a_chip_select_n && port_a.port_a_write_not_read
      && !port_a.port_a_mail_select && port_a.port_a_enable;
   assign b_read_select = !port_b.port_b_chip_select_n && port_b.port_b_write_not_read
      && !port_b.port_b_mail_select && port_b.port_b_enable;
   assign fifo_write = a_write_select && state.input_ready;
   // A read only moves the output word when the buffer can take it
   assign fifo_read = b_read_select && state.output_ready && buffer_ready;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      words_a = '0;
      words_b = '0;
      // Pointer views cross between the ports through two stages
      next_state.wr_sync1 = state.wr_ptr;
      next_state.wr_sync2 = state.wr_sync1;
      next_state.rd_sync1 = state.rd_view;
      next_state.rd_sync2 = state.rd_sync1;

      // Offset programming
      case (state.phase)
         DCFF_PROG_X: begin
            if (serial_in.serial_program) begin
               if (serial_in.serial_shift) begin
                  {next_state.x_offset, next_state.y_offset} =
                     {state.x_offset[`DCFF_OFFSET_W-2:0], state.y_offset, serial_in.serial_bit};
                  next_state.serial_count = state.serial_count + 1'b1;
                  if (state.serial_count == `DCFF_SERIAL_CNT_W'(`DCFF_SERIAL_BITS - 1)) begin
                     next_state.phase = DCFF_RUN;
                  end
               end
            end else if (a_write_select) begin
               next_state.x_offset = port_a.port_a_data[`DCFF_OFFSET_W-1:0];
               next_state.phase = DCFF_PROG_Y;
            end
         end
         DCFF_PROG_Y: begin
            if (a_write_select) begin
               next_state.y_offset = port_a.port_a_data[`DCFF_OFFSET_W-1:0];
               next_state.phase = DCFF_RUN;
            end
         end
         DCFF_RUN: begin
            if (fifo_write) begin
               next_state.wr_ptr = state.wr_ptr + 1'b1;
            end
         end
         default: begin
            next_state.phase = DCFF_PROG_X;
         end
      endcase

      // Retransmit mode, driven by its request and output ready only
      if (!state.retransmit_active && port_b.retransmit_mode_request
          && state.output_ready) begin
         next_state.retransmit_active = 1'b1;
         next_state.shadow_ptr = state.rd_ptr - 1'b1;
      end else if (state.retransmit_active && !port_b.retransmit_mode_request) begin
         next_state.retransmit_active = 1'b0;
      end

      // Output register: replay, fall-through or drain
      if (state.retransmit_active && port_b.replay_from_marker
          && port_b.retransmit_mode_request) begin
         next_state.out_word = memory[state.shadow_ptr[`DCFF_ADDR_W-1:0]];
         next_state.rd_ptr = state.shadow_ptr + 1'b1;
         next_state.output_ready = 1'b1;
      end else if ((!state.output_ready || fifo_read)
                   && state.rd_ptr != state.wr_sync2) begin
         next_state.out_word = memory[state.rd_ptr[`DCFF_ADDR_W-1:0]];
         next_state.rd_ptr = state.rd_ptr + 1'b1;
         next_state.output_ready = 1'b1;
      end else if (fifo_read) begin
         next_state.output_ready = 1'b0;
      end

      // Write side sees the shadow pointer while replaying is possible
      next_state.rd_view = next_state.retransmit_active ? next_state.shadow_ptr
         : next_state.rd_ptr;

      // Read-side level excludes the word held in the output register
      words_b = state.wr_sync2 - next_state.rd_ptr;
      next_state.almost_empty_flag_n =
         (words_b > {1'b0, state.x_offset});

      // Write-side level counts this cycle's write at once, frees late
      words_a = next_state.wr_ptr - state.rd_sync2;
      next_state.input_ready = (state.phase == DCFF_RUN)
         && (words_a != `DCFF_PTR_W'(`DCFF_DEPTH));
      next_state.almost_full_flag_n = (words_a <
         (`DCFF_PTR_W'(`DCFF_DEPTH) - {1'b0, state.y_offset}));
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= '0;
         state.phase <= DCFF_PROG_X;
         state.x_offset <= `DCFF_OFFSET_RESET;
         state.y_offset <= `DCFF_OFFSET_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Array has no reset: the pointers say what is valid
   always_ff @(posedge clk) begin
      if (fifo_write) begin
         memory[state.wr_ptr[`DCFF_ADDR_W-1:0]] <= port_a.port_a_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read words queue here so a slow consumer stalls reads, not data
   dcff_out_fifo #(
      .WIDTH(`DCFF_DATA_W),
      .DEPTH(`DCFF_OUT_FIFO_DEPTH)
   ) out_buffer (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(fifo_read),
      .in_ready(buffer_ready),
      .in_data(state.out_word),
      .out_valid(b_data_valid),
      .out_ready(b_data_ready),
      .out_data(b_data)
   );

   assign input_ready = state.input_ready;
   assign almost_full_flag_n = state.almost_full_flag_n;
   assign output_ready = state.output_ready;
   assign almost_empty_flag_n = state.almost_empty_flag_n;
   assign retransmit_active = state.retransmit_active;

endmodule : dcff_flag_timing

// [testbench/dcff_checker.sv]
/*
 Flag and retransmit timing checker for dcff_flag_timing.
 Assumes a bind to the top module; one clock for both ports.
*/
`timescale 1ns/10ps
`include "dcff_params.svh"

module dcff_checker
   import dcff_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire dcff_port_a_type port_a,
   input wire dcff_port_b_type port_b,
   input wire logic input_ready,
   input wire logic output_ready,
   input wire logic almost_empty_flag_n,
   input wire logic retransmit_active,
   input wire logic b_data_valid,
   input wire logic b_data_ready,
   input wire logic [`DCFF_DATA_W-1:0] b_data
);
   logic wr;
   assign wr = !port_a.port_a_chip_select_n && port_a.port_a_write_not_read &&
      !port_a.port_a_mail_select && port_a.port_a_enable;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   a_fall_through: assert property (
      $rose(output_ready) && !retransmit_active |-> $past(wr, 4) && $past(input_ready, 4))
      else $error("output ready rose without a write four edges before");
   // Replay can lift the flag a little after leaving, so recent retransmit is excluded
   a_ae_sync: assert property (
      $rose(almost_empty_flag_n) && !retransmit_active && !$past(retransmit_active) &&
      !$past(retransmit_active, 2) && !$past(retransmit_active, 3) |-> $past(wr, 4))
      else $error("almost empty rose without a write four edges before");
   a_enter_rtx: assert property (
      port_b.retransmit_mode_request && output_ready |=> retransmit_active)
      else $error("retransmit mode not entered");
   a_leave_rtx: assert property (
      !port_b.retransmit_mode_request |=> !retransmit_active)
      else $error("retransmit mode not left");
   a_replay_ready: assert property (
      retransmit_active && port_b.retransmit_mode_request && port_b.replay_from_marker
      |=> output_ready) else $error("replay left output ready low");
   a_ready_reset: assert property (
      $rose(rst_b) |-> !input_ready [*2]) else $error("input ready high before programming");
   a_buf_valid: assert property (
      b_data_valid && !b_data_ready |=> b_data_valid) else $error("buffer lost a word");
   a_head_stable: assert property (
      b_data_valid && !b_data_ready |=> $stable(b_data)) else $error("buffer head moved");
endmodule : dcff_checker

bind dcff_flag_timing dcff_checker i_dcff_checker (.clk(clk), .rst_b(rst_b), .port_a(port_a),
   .port_b(port_b), .input_ready(input_ready), .output_ready(output_ready),
   .almost_empty_flag_n(almost_empty_flag_n), .retransmit_active(retransmit_active),
   .b_data_valid(b_data_valid), .b_data_ready(b_data_ready), .b_data(b_data));

// [testbench/dcff_sink.sv]
/*
 Consumer on the buffered read side, stalling while asked.
 Assumes the bench drives stall and reads the got queue.
*/
`timescale 1ns/10ps
`include "dcff_params.svh"

module dcff_sink
   import dcff_pkg::*;
(
   input wire logic clk,
   input wire logic stall,
   input wire logic valid,
   input wire logic [`DCFF_DATA_W-1:0] data,
   output logic ready
);
   logic [`DCFF_DATA_W-1:0] got[$];
   assign ready = !stall;
   always @(posedge clk) begin
      if (valid && ready) begin
         got.push_back(data);
      end
   end
endmodule : dcff_sink

// [testbench/testbench.sv]
/*
 Directed bench for dcff_flag_timing: offsets, fall-through, flags, retransmit.
 Assumes the checker is bound and dcff_sink drains the buffer.
*/
`timescale 1ns/10ps
`include "dcff_params.svh"

module testbench
   import dcff_pkg::*;
;
   logic clk, rst_b, stall, input_ready, almost_full_flag_n, output_ready;
   logic almost_empty_flag_n, retransmit_active, b_data_valid, b_data_ready;
   logic [`DCFF_DATA_W-1:0] b_data;
   dcff_port_a_type port_a;
   dcff_port_b_type port_b;
   dcff_serial_type serial_in;
   int miscompares, num_checks, n, cnt;
   dcff_flag_timing i_dcff_flag_timing (.clk(clk), .rst_b(rst_b), .port_a(port_a),
      .port_b(port_b), .serial_in(serial_in), .input_ready(input_ready),
      .almost_full_flag_n(almost_full_flag_n), .output_ready(output_ready),
      .almost_empty_flag_n(almost_empty_flag_n), .retransmit_active(retransmit_active),
      .b_data_valid(b_data_valid), .b_data_ready(b_data_ready), .b_data(b_data));
   dcff_sink i_dcff_sink (.clk(clk), .stall(stall), .valid(b_data_valid), .data(b_data),
      .ready(b_data_ready));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [35:0] got, input logic [35:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Selects stay asserted; only the enable strobes, so one edge takes each request
   task wr(input logic [35:0] d);
      @(posedge clk);
      port_a.port_a_enable <= 1'b1;
      port_a.port_a_data <= d;
      @(posedge clk);
      port_a.port_a_enable <= 1'b0;
   endtask : wr
   task rd;
      @(posedge clk);
      port_b.port_b_enable <= 1'b1;
      @(posedge clk);
      port_b.port_b_enable <= 1'b0;
   endtask : rd
   task edges(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : edges
   task lag(input int sel, input int exp);
      for (n = 1; n < 9; n++) begin
         edges(1);
         if ((sel == 0 && input_ready) || (sel == 1 && almost_full_flag_n) ||
            (sel == 2 && output_ready)) break;
      end
      chk(36'(n), 36'(exp));
   endtask : lag
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   initial begin
      #3000000;
      miscompares++;
      conclude;
   end
   initial begin
      rst_b = 1'b0;
      stall = 1'b0;
      port_a = '{1'b0, 1'b1, 1'b0, 1'b0, '0};
      port_b = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      serial_in = '0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      serial_in.serial_program <= 1'b1;
      wr(36'h0_0000_00aa);
      // X = 2 then Y = 3, most significant bit first, idle cycles between bits
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         @(posedge clk);
         serial_in.serial_shift <= 1'b1;
         serial_in.serial_bit <= (i == 8 || i >= 18);
         @(posedge clk);
         serial_in.serial_shift <= 1'b0;
      end
      lag(0, 1);
      serial_in.serial_program <= 1'b0;
      chk(output_ready, 1'b0);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      wr(36'h0_0000_0002);
      @(posedge clk);
      wr(36'h0_0000_0003);
      lag(0, 1);
      wr({4'h5, 32'd1});
      lag(2, 3);
      wr({4'h5, 32'd2});
      wr({4'h5, 32'd3});
      edges(4);
      chk(almost_empty_flag_n, 1'b0);
      wr({4'h5, 32'd4});
      edges(2);
      chk(almost_empty_flag_n, 1'b0);
      edges(1);
      chk(almost_empty_flag_n, 1'b1);
      stall <= 1'b1;
      repeat (4) rd;
      edges(1);
      chk(b_data, {4'h5, 32'd1});
      chk(output_ready, 1'b0);
      stall <= 1'b0;
      edges(6);
      for (int k = 0; k < 4; k++) chk(i_dcff_sink.got[k], {4'h5, 32'(k + 1)});
      cnt = 0;
      while (input_ready === 1'b1 && cnt < 1100) begin
         wr(36'(cnt));
         #1;
         cnt++;
      end
      chk(36'(cnt), 36'd1025);
      chk(almost_full_flag_n, 1'b0);
      rd;
      lag(0, 3);
      rd;
      rd;
      edges(4);
      chk(almost_full_flag_n, 1'b0);
      rd;
      lag(1, 3);
      // Chip select dropped on purpose: mode entry must not depend on it
      @(posedge clk);
      port_b.retransmit_mode_request <= 1'b1;
      port_b.port_b_chip_select_n <= 1'b1;
      cnt = 0;
      while (input_ready === 1'b1 && cnt < 8) begin
         wr(36'(cnt));
         #1;
         cnt++;
      end
      port_b.port_b_chip_select_n <= 1'b0;
      chk(retransmit_active, 1'b1);
      rd;
      rd;
      @(posedge clk);
      port_b.replay_from_marker <= 1'b1;
      @(posedge clk);
      port_b.replay_from_marker <= 1'b0;
      #1;
      chk(output_ready, 1'b1);
      repeat (5) rd;
      // Marked word was the fifth fill word, value 4; it must come out again
      chk(i_dcff_sink.got[10], 36'h0_0000_0004);
      @(posedge clk);
      port_b.retransmit_mode_request <= 1'b0;
      edges(3);
      chk(input_ready, 1'b0);
      edges(1);
      chk(input_ready, 1'b1);
      chk(almost_full_flag_n, 1'b1);
      conclude;
   end
endmodule : testbench
